// ==== logic/sdc_bank.sv ====
// Playback control bank: register set, sample FIFO and output processing
`default_nettype none

// Synchronous FIFO with valid/ready on both sides
module sdc_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic [AW:0] nxt_count;
	logic ready_ff;
	logic push;
	logic pop;

	// Ready is registered so the source sees back-pressure from a flop
	assign push = in_valid && ready_ff;
	assign pop = out_valid && out_ready;
	assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready = ready_ff;
	assign out_valid = (count_ff != '0);
	assign out_data = mem[rd_ptr_ff];

	// Storage array has no reset; only pointers matter
	always_ff @(posedge mclk)
	begin
		if (push)
		begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge mclk)
	begin
		if (!rst_n || clear)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			ready_ff <= 1'b0;
		end
		else
		begin
			wr_ptr_ff <= push ? wr_ptr_ff + AW'(1) : wr_ptr_ff;
			rd_ptr_ff <= pop ? rd_ptr_ff + AW'(1) : rd_ptr_ff;
			count_ff <= nxt_count;
			ready_ff <= (nxt_count != (AW+1)'(DEPTH));
		end
	end
endmodule

// Top: control registers and playback processing towards the converter cores
module sdc_bank (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [sdc_pkg::SAMPLE_W-1:0] in_left,
	input wire logic [sdc_pkg::SAMPLE_W-1:0] in_right,
	output logic out_valid,
	input wire logic out_ready,
	output logic [sdc_pkg::SAMPLE_W-1:0] out_left,
	output logic [sdc_pkg::SAMPLE_W-1:0] out_right,
	input wire logic dev_irq,
	output logic conv_hard_reset,
	output logic conv_out_agnd,
	output logic conv_clk_en,
	output logic [1:0] interpolation_ratio,
	output logic [1:0] deemphasis_select,
	output logic left_zero_pin,
	output logic right_zero_pin
);
	localparam int SW = sdc_pkg::SAMPLE_W;
	localparam int GW = sdc_pkg::GAIN_W;

	logic [7:0] routing_ff;
	logic [7:0] clock_filter_ff;
	logic [7:0] zero_ctrl_ff;
	logic [7:0] pin_ctrl_ff;
	logic [7:0] left_gain_code_ff;
	logic [7:0] right_gain_code_ff;
	logic [7:0] rdata_ff;
	logic [SW-2:0] left_peak_ff;
	logic [SW-2:0] right_peak_ff;
	logic [1:0] ratio_ff;
	logic hard_reset_ff;
	logic agnd_ff;
	logic [1:0] div_cnt_ff;
	logic clk_en_ff;
	logic out_valid_ff;
	logic [SW-1:0] out_left_ff;
	logic [SW-1:0] out_right_ff;
	logic left_data_zero_ff;
	logic right_data_zero_ff;
	logic left_pin_ff;
	logic right_pin_ff;

	logic logic_clear;
	logic fifo_valid;
	logic fifo_ready;
	logic [2*SW-1:0] fifo_data;
	logic take;
	logic [SW-1:0] src_left;
	logic [SW-1:0] src_right;
	logic [SW-1:0] route_left;
	logic [SW-1:0] route_right;
	logic [SW-1:0] nxt_left;
	logic [SW-1:0] nxt_right;
	logic [1:0] route_sel;
	logic [1:0] invert_sel;
	logic [1:0] divide_sel;
	logic left_zero;
	logic right_zero;
	logic level;
	logic rd_left_peak;
	logic rd_right_peak;

	// Negate with clamp so the most negative code does not wrap to itself
	function automatic logic [SW-1:0] neg_sat(input logic [SW-1:0] x);
		if (x == {1'b1, {(SW-1){1'b0}}})
		begin
			return {1'b0, {(SW-1){1'b1}}};
		end
		return SW'(-x);
	endfunction

	// Magnitude of a signed sample, clamped to the positive range
	function automatic logic [SW-2:0] magnitude(input logic [SW-1:0] x);
		logic [SW-1:0] p;
		p = x[SW-1] ? neg_sat(x) : x;
		return p[SW-2:0];
	endfunction

	// Attenuation in 0.375 dB steps: sixteen steps make 6 dB, taken as one shift;
	// the residual steps come from a small mantissa table
	function automatic logic [SW-1:0] apply_gain(input logic [SW-1:0] x, input logic [7:0] code);
		logic [7:0] att;
		logic [GW-1:0] mant;
		logic signed [SW+GW:0] prod;
		logic signed [SW-1:0] scaled;
		att = sdc_pkg::GAIN_FULL_SCALE - code;
		// Full scale passes the sample untouched; the table tops out just below unity
		if (att == 8'h00)
		begin
			return x;
		end
		unique case (att[3:0])
			4'h0: mant = 16'hffff;
			4'h1: mant = 16'hf52e;
			4'h2: mant = 16'heacf;
			4'h3: mant = 16'he0e6;
			4'h4: mant = 16'hd766;
			4'h5: mant = 16'hce4d;
			4'h6: mant = 16'hc595;
			4'h7: mant = 16'hbd3c;
			4'h8: mant = 16'hb53c;
			4'h9: mant = 16'had94;
			4'ha: mant = 16'ha63e;
			4'hb: mant = 16'h9f37;
			4'hc: mant = 16'h987d;
			4'hd: mant = 16'h920b;
			4'he: mant = 16'h8bd0;
			4'hf: mant = 16'h85f7;
		endcase
		prod = $signed(x) * $signed({1'b0, mant});
		scaled = SW'(prod >>> GW);
		return SW'(scaled >>> att[7:4]);
	endfunction

	// Level in whole dB below full scale: 6 dB per leading zero plus a mantissa term
	function automatic logic [5:0] peak_code(input logic [SW-2:0] mag);
		int lz;
		int frac;
		int db;
		lz = SW - 1;
		frac = 0;
		for (int i = 0; i < SW - 1; i++)
		begin
			if (mag[i])
			begin
				lz = SW - 2 - i;
			end
		end
		if (lz >= SW - 1)
		begin
			return sdc_pkg::PEAK_FLOOR;
		end
		if (lz <= SW - 5)
		begin
			unique case (3'(mag >> (SW - 5 - lz)))
				3'h0: frac = 6;
				3'h1: frac = 4;
				3'h2: frac = 4;
				3'h3: frac = 3;
				3'h4: frac = 2;
				3'h5: frac = 1;
				3'h6: frac = 1;
				3'h7: frac = 0;
			endcase
		end
		db = lz * 6 + frac;
		return (db > 63) ? sdc_pkg::PEAK_FLOOR : 6'(db);
	endfunction

	// Zero flag of one channel from its two causes
	function automatic logic zero_flag(input logic silence_n, input logic [7:0] code, input logic data_zero);
		logic by_volume;
		logic by_data;
		by_volume = !zero_ctrl_ff[sdc_pkg::ZERO_ON_VOLUME_DISABLE_BIT]
			&& (!silence_n || code == 8'h00);
		by_data = !zero_ctrl_ff[sdc_pkg::ZERO_ON_DATA_DISABLE_BIT] && data_zero;
		return by_volume || by_data;
	endfunction

	// Either reset bit clears the playback logic; the registers below survive it
	assign logic_clear = routing_ff[sdc_pkg::FULL_RESET_POWERDOWN_BIT]
		|| routing_ff[sdc_pkg::DIGITAL_CORE_RESET_BIT];

	sdc_fifo #(
		.WIDTH(2*SW),
		.DEPTH(sdc_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(logic_clear),
		.in_valid(in_valid),
		.in_ready(fifo_ready),
		.in_data({in_left, in_right}),
		.out_valid(fifo_valid),
		.out_ready(take),
		.out_data(fifo_data)
	);

	// Register writes; reserved bits are masked away
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			routing_ff <= sdc_pkg::RST_RESET_ROUTING;
			clock_filter_ff <= sdc_pkg::RST_CLOCK_FILTER;
			zero_ctrl_ff <= sdc_pkg::RST_ZERO_FLAG;
			pin_ctrl_ff <= sdc_pkg::RST_PIN_FUNCTION;
			left_gain_code_ff <= sdc_pkg::RST_VOLUME;
			right_gain_code_ff <= sdc_pkg::RST_VOLUME;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				sdc_pkg::ADDR_RESET_ROUTING: routing_ff <= reg_wdata & sdc_pkg::MASK_RESET_ROUTING;
				sdc_pkg::ADDR_CLOCK_FILTER: clock_filter_ff <= reg_wdata & sdc_pkg::MASK_CLOCK_FILTER;
				sdc_pkg::ADDR_ZERO_FLAG: zero_ctrl_ff <= reg_wdata & sdc_pkg::MASK_ZERO_FLAG;
				sdc_pkg::ADDR_PIN_FUNCTION: pin_ctrl_ff <= reg_wdata & sdc_pkg::MASK_PIN_FUNCTION;
				sdc_pkg::ADDR_LEFT_VOLUME: left_gain_code_ff <= reg_wdata & sdc_pkg::MASK_VOLUME;
				sdc_pkg::ADDR_RIGHT_VOLUME: right_gain_code_ff <= reg_wdata & sdc_pkg::MASK_VOLUME;
				default: ;
			endcase
		end
	end

	// Read data is captured into a flop one cycle after the strobe
	assign rd_left_peak = reg_rd && reg_addr == sdc_pkg::ADDR_LEFT_PEAK;
	assign rd_right_peak = reg_rd && reg_addr == sdc_pkg::ADDR_RIGHT_PEAK;
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rdata_ff <= 8'h00;
		end
		else if (reg_rd)
		begin
			unique case (reg_addr)
				sdc_pkg::ADDR_RESET_ROUTING: rdata_ff <= routing_ff;
				sdc_pkg::ADDR_CLOCK_FILTER: rdata_ff <= clock_filter_ff;
				sdc_pkg::ADDR_ZERO_FLAG: rdata_ff <= zero_ctrl_ff;
				sdc_pkg::ADDR_PIN_FUNCTION: rdata_ff <= pin_ctrl_ff;
				sdc_pkg::ADDR_LEFT_VOLUME: rdata_ff <= left_gain_code_ff;
				sdc_pkg::ADDR_RIGHT_VOLUME: rdata_ff <= right_gain_code_ff;
				sdc_pkg::ADDR_LEFT_PEAK: rdata_ff <= {2'b00, peak_code(left_peak_ff)};
				sdc_pkg::ADDR_RIGHT_PEAK: rdata_ff <= {2'b00, peak_code(right_peak_ff)};
				default: rdata_ff <= 8'h00;
			endcase
		end
	end

	// Hard reset and analog ground follow the full reset bit
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			hard_reset_ff <= 1'b0;
			agnd_ff <= 1'b0;
		end
		else
		begin
			hard_reset_ff <= routing_ff[sdc_pkg::FULL_RESET_POWERDOWN_BIT];
			agnd_ff <= routing_ff[sdc_pkg::FULL_RESET_POWERDOWN_BIT];
		end
	end

	// A reserved ratio code keeps the last legal ratio rather than reach the core
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ratio_ff <= 2'h0;
		end
		else if (clock_filter_ff[sdc_pkg::RATIO_LSB +: 2] != sdc_pkg::RATIO_RESERVED)
		begin
			ratio_ff <= clock_filter_ff[sdc_pkg::RATIO_LSB +: 2];
		end
	end

	// Converter clock enable: /1.5 is two enables in three cycles, so jitter is traded for one clock
	assign divide_sel = clock_filter_ff[sdc_pkg::DIVIDE_LSB +: 2];
	always_ff @(posedge mclk)
	begin
		if (!rst_n || logic_clear)
		begin
			div_cnt_ff <= 2'h0;
			clk_en_ff <= 1'b0;
		end
		else
		begin
			unique case (divide_sel)
				2'h0:
				begin
					div_cnt_ff <= 2'h0;
					clk_en_ff <= 1'b1;
				end
				2'h1:
				begin
					div_cnt_ff <= (div_cnt_ff >= 2'h2) ? 2'h0 : div_cnt_ff + 2'h1;
					clk_en_ff <= (div_cnt_ff != 2'h2);
				end
				2'h2:
				begin
					div_cnt_ff <= {1'b0, ~div_cnt_ff[0]};
					clk_en_ff <= (div_cnt_ff[0] == 1'b0);
				end
				2'h3:
				begin
					div_cnt_ff <= (div_cnt_ff >= 2'h2) ? 2'h0 : div_cnt_ff + 2'h1;
					clk_en_ff <= (div_cnt_ff == 2'h0);
				end
			endcase
		end
	end

	// Sample path: route, invert, silence, scale
	assign take = fifo_valid && (!out_valid_ff || out_ready);
	assign src_left = fifo_data[2*SW-1:SW];
	assign src_right = fifo_data[SW-1:0];
	assign route_sel = routing_ff[sdc_pkg::ROUTE_LSB +: 2];
	assign invert_sel = routing_ff[sdc_pkg::INVERT_LSB +: 2];
	always_comb
	begin
		unique case (route_sel)
			2'h0:
			begin
				route_left = src_left;
				route_right = src_right;
			end
			2'h1:
			begin
				route_left = src_right;
				route_right = src_right;
			end
			2'h2:
			begin
				route_left = src_left;
				route_right = src_left;
			end
			2'h3:
			begin
				route_left = src_right;
				route_right = src_left;
			end
		endcase
		nxt_left = invert_sel[0] ? neg_sat(route_left) : route_left;
		nxt_right = invert_sel[1] ? neg_sat(route_right) : route_right;
		nxt_left = routing_ff[sdc_pkg::LEFT_SILENCE_N_BIT]
			? apply_gain(nxt_left, left_gain_code_ff) : '0;
		nxt_right = routing_ff[sdc_pkg::RIGHT_SILENCE_N_BIT]
			? apply_gain(nxt_right, right_gain_code_ff) : '0;
	end

	// Output stage holds a sample until the converter accepts it
	always_ff @(posedge mclk)
	begin
		if (!rst_n || logic_clear)
		begin
			out_valid_ff <= 1'b0;
			out_left_ff <= '0;
			out_right_ff <= '0;
			left_data_zero_ff <= 1'b0;
			right_data_zero_ff <= 1'b0;
		end
		else
		begin
			if (take)
			begin
				out_valid_ff <= 1'b1;
				out_left_ff <= nxt_left;
				out_right_ff <= nxt_right;
				left_data_zero_ff <= (route_left == '0);
				right_data_zero_ff <= (route_right == '0);
			end
			else if (out_ready)
			begin
				out_valid_ff <= 1'b0;
			end
		end
	end

	// Peak hold: a read restarts from the incoming sample, so a sample in the read cycle is not lost
	always_ff @(posedge mclk)
	begin
		if (!rst_n || logic_clear)
		begin
			left_peak_ff <= '0;
			right_peak_ff <= '0;
		end
		else
		begin
			if (rd_left_peak)
			begin
				left_peak_ff <= take ? magnitude(nxt_left) : '0;
			end
			else if (take && magnitude(nxt_left) > left_peak_ff)
			begin
				left_peak_ff <= magnitude(nxt_left);
			end
			if (rd_right_peak)
			begin
				right_peak_ff <= take ? magnitude(nxt_right) : '0;
			end
			else if (take && magnitude(nxt_right) > right_peak_ff)
			begin
				right_peak_ff <= magnitude(nxt_right);
			end
		end
	end

	// Zero and interrupt pins
	assign left_zero = zero_flag(routing_ff[sdc_pkg::LEFT_SILENCE_N_BIT], left_gain_code_ff, left_data_zero_ff);
	assign right_zero = zero_flag(routing_ff[sdc_pkg::RIGHT_SILENCE_N_BIT], right_gain_code_ff, right_data_zero_ff);
	assign level = zero_ctrl_ff[sdc_pkg::ZERO_FLAG_LEVEL_BIT];
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			left_pin_ff <= 1'b1;
			right_pin_ff <= 1'b1;
		end
		else if (pin_ctrl_ff[sdc_pkg::LEFT_PIN_IRQ_SELECT_BIT])
		begin
			left_pin_ff <= dev_irq;
			unique case (pin_ctrl_ff[sdc_pkg::RIGHT_PIN_FUNCTION_LSB +: 2])
				2'h0: right_pin_ff <= right_zero ~^ level;
				2'h1: right_pin_ff <= left_zero ~^ level;
				2'h2: right_pin_ff <= (left_zero || right_zero) ~^ level;
				2'h3: right_pin_ff <= (left_zero && right_zero) ~^ level;
			endcase
		end
		else
		begin
			left_pin_ff <= left_zero ~^ level;
			right_pin_ff <= right_zero ~^ level;
		end
	end

	assign reg_rdata = rdata_ff;
	assign in_ready = fifo_ready;
	assign out_valid = out_valid_ff;
	assign out_left = out_left_ff;
	assign out_right = out_right_ff;
	assign conv_hard_reset = hard_reset_ff;
	assign conv_out_agnd = agnd_ff;
	assign conv_clk_en = clk_en_ff;
	assign interpolation_ratio = ratio_ff;
	assign deemphasis_select = clock_filter_ff[sdc_pkg::DEEMPH_LSB +: 2];
	assign left_zero_pin = left_pin_ff;
	assign right_zero_pin = right_pin_ff;
endmodule
`default_nettype wire

// ==== logic/sdc_pkg.sv ====
// Package of register map, field layout, reset values and sizes for the playback control bank
`default_nettype none
package sdc_pkg;
	// Register addresses on the control port
	localparam logic [6:0] ADDR_RESET_ROUTING = 7'h64;
	localparam logic [6:0] ADDR_CLOCK_FILTER = 7'h65;
	localparam logic [6:0] ADDR_ZERO_FLAG = 7'h66;
	localparam logic [6:0] ADDR_PIN_FUNCTION = 7'h67;
	localparam logic [6:0] ADDR_LEFT_VOLUME = 7'h68;
	localparam logic [6:0] ADDR_RIGHT_VOLUME = 7'h69;
	localparam logic [6:0] ADDR_LEFT_PEAK = 7'h6a;
	localparam logic [6:0] ADDR_RIGHT_PEAK = 7'h6b;
	// Writable bit masks; reserved bits are dropped on write and read as zero
	localparam logic [7:0] MASK_RESET_ROUTING = 8'hff;
	localparam logic [7:0] MASK_CLOCK_FILTER = 8'h3f;
	localparam logic [7:0] MASK_ZERO_FLAG = 8'h07;
	localparam logic [7:0] MASK_PIN_FUNCTION = 8'h70;
	localparam logic [7:0] MASK_VOLUME = 8'hff;
	// Reset values
	localparam logic [7:0] RST_RESET_ROUTING = 8'h03;
	localparam logic [7:0] RST_CLOCK_FILTER = 8'h00;
	localparam logic [7:0] RST_ZERO_FLAG = 8'h00;
	localparam logic [7:0] RST_PIN_FUNCTION = 8'h00;
	localparam logic [7:0] RST_VOLUME = 8'hff;
	// Field positions in the reset and routing register
	localparam int FULL_RESET_POWERDOWN_BIT = 7;
	localparam int DIGITAL_CORE_RESET_BIT = 6;
	localparam int ROUTE_LSB = 4;
	localparam int INVERT_LSB = 2;
	localparam int RIGHT_SILENCE_N_BIT = 1;
	localparam int LEFT_SILENCE_N_BIT = 0;
	// Field positions in the clock and filter register
	localparam int DIVIDE_LSB = 4;
	localparam int RATIO_LSB = 2;
	localparam int DEEMPH_LSB = 0;
	// Field positions in the zero flag and pin function registers
	localparam int ZERO_ON_VOLUME_DISABLE_BIT = 2;
	localparam int ZERO_ON_DATA_DISABLE_BIT = 1;
	localparam int ZERO_FLAG_LEVEL_BIT = 0;
	localparam int LEFT_PIN_IRQ_SELECT_BIT = 6;
	localparam int RIGHT_PIN_FUNCTION_LSB = 4;
	// Reserved interpolation code
	localparam logic [1:0] RATIO_RESERVED = 2'h3;
	// Sample, buffer and gain geometry, peak floor code and full-scale gain code
	localparam int SAMPLE_W = 24;
	localparam int FIFO_DEPTH = 16;
	localparam int GAIN_W = 16;
	localparam logic [5:0] PEAK_FLOOR = 6'h3f;
	localparam logic [7:0] GAIN_FULL_SCALE = 8'hff;
endpackage
`default_nettype wire

// ==== testbench/sdc_bank_bench.sv ====
// Self-checking bench for the playback control bank
`default_nettype none
module sdc_bank_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst_n, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready, dev_irq;
	logic conv_hard_reset, conv_out_agnd, conv_clk_en, left_zero_pin, right_zero_pin;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv;
	logic [1:0] interpolation_ratio, deemphasis_select;
	logic [23:0] in_left, in_right, out_left, out_right, el, er, ol, orr;
	logic [7:0] rst_tab [6] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
	logic [7:0] div_tab [4] = '{8'h06, 8'h04, 8'h03, 8'h02};
	logic rpin_tab [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	localparam logic [23:0] VA = 24'h10_0000;
	localparam logic [23:0] VB = 24'h20_0000;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int n;
	sdc_bank dut (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .in_valid, .in_ready,
		.in_left, .in_right, .out_valid, .out_ready, .out_left, .out_right, .dev_irq, .conv_hard_reset,
		.conv_out_agnd, .conv_clk_en, .interpolation_ratio, .deemphasis_select, .left_zero_pin, .right_zero_pin);
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic conclude();
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Ceiling is far above the few hundred cycles the sequence needs
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			conclude();
		end
	end
	task automatic miss(input logic [23:0] g, input logic [23:0] e);
		bad_count++;
		$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
	endtask
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e)
			miss(24'(g), 24'(e));
	endtask
	task automatic chk_smp(input logic [23:0] g, input logic [23:0] e);
		num_checks++;
		if (g !== e)
			miss(g, e);
	endtask
	task automatic chk_pin(input logic g, input logic e);
		num_checks++;
		if (g !== e)
			miss(24'(g), 24'(e));
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Read data lands at the taking edge, so it is sampled just after it
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk_reg(reg_rdata, e);
	endtask
	task automatic send(input logic [23:0] l, input logic [23:0] r);
		@(posedge mclk);
		in_left <= l;
		in_right <= r;
		in_valid <= 1'b1;
		do @(posedge mclk); while (in_ready !== 1'b1);
		in_valid <= 1'b0;
	endtask
	task automatic take();
		@(posedge mclk);
		out_ready <= 1'b1;
		do @(posedge mclk); while (out_valid !== 1'b1);
		ol = out_left;
		orr = out_right;
		out_ready <= 1'b0;
	endtask
	// Pins settle a couple of cycles after the flag cause changes
	task automatic pins(input logic l, input logic r);
		repeat (4) @(posedge mclk);
		chk_pin(left_zero_pin, l);
		chk_pin(right_zero_pin, r);
	endtask
	initial
	begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 8'h00;
		in_valid = 1'b0;
		out_ready = 1'b0;
		dev_irq = 1'b0;
		in_left = 24'h00_0000;
		in_right = 24'h00_0000;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) rchk(7'h64 + 7'(i), rst_tab[i]);
		pins(1'b1, 1'b1);
		rchk(7'h70, 8'h00);
		// Reserved bits and the reserved ratio code are dropped
		wr(7'h65, 8'hff);
		rchk(7'h65, 8'h3f);
		chk_reg({6'h00, interpolation_ratio}, 8'h00);
		chk_reg({6'h00, deemphasis_select}, 8'h03);
		wr(7'h66, 8'hff);
		rchk(7'h66, 8'h07);
		wr(7'h67, 8'hff);
		rchk(7'h67, 8'h70);
		wr(7'h66, 8'h00);
		wr(7'h67, 8'h00);
		wr(7'h6a, 8'hff);
		rchk(7'h6a, 8'h3f);
		for (int r = 0; r < 3; r++)
		begin
			wr(7'h65, 8'(r * 5));
			repeat (2) @(posedge mclk);
			chk_reg({6'h00, interpolation_ratio}, 8'(r));
			chk_reg({6'h00, deemphasis_select}, 8'(r));
		end
		// Enable count over six cycles is phase independent for every divide setting
		for (int d = 0; d < 4; d++)
		begin
			wr(7'h65, 8'(d * 16));
			repeat (4) @(posedge mclk);
			n = 0;
			repeat (6)
			begin
				@(posedge mclk);
				if (conv_clk_en === 1'b1)
					n++;
			end
			chk_reg(8'(n), div_tab[d]);
		end
		// Every route and invert combination at full volume
		for (int i = 0; i < 16; i++)
		begin
			wr(7'h64, 8'(i * 4 + 3));
			send(VA, VB);
			take();
			el = i[2] ? VB : VA;
			er = i[3] ? VA : VB;
			if (i[0])
				el = -el;
			if (i[1])
				er = -er;
			chk_smp(ol, el);
			chk_smp(orr, er);
		end
		wr(7'h64, 8'h02);
		send(VA, VB);
		take();
		chk_smp(ol, 24'h00_0000);
		chk_smp(orr, VB);
		pins(1'b0, 1'b1);
		wr(7'h66, 8'h01);
		pins(1'b1, 1'b0);
		wr(7'h66, 8'h05);
		pins(1'b0, 1'b0);
		wr(7'h66, 8'h01);
		wr(7'h64, 8'h03);
		send(24'h00_0000, VB);
		take();
		pins(1'b1, 1'b0);
		wr(7'h66, 8'h03);
		pins(1'b0, 1'b0);
		// Interrupt mode: left muted so only the left flag is raised
		wr(7'h66, 8'h01);
		wr(7'h64, 8'h02);
		for (int s = 0; s < 4; s++)
		begin
			wr(7'h67, 8'(64 + s * 16));
			dev_irq <= s[0];
			pins(s[0], rpin_tab[s]);
		end
		wr(7'h67, 8'h00);
		dev_irq <= 1'b0;
		wr(7'h64, 8'h03);
		wr(7'h68, 8'h00);
		send(VA, VB);
		take();
		chk_pin(ol < 24'h00_0400, 1'b1);
		chk_smp(orr, VB);
		pins(1'b1, 1'b0);
		wr(7'h68, 8'hff);
		rchk(7'h68, 8'hff);
		// Peak registers: clear, measure, then a second read sees the restart
		wr(7'h66, 8'h00);
		rchk(7'h6b, 8'h0c);
		wr(7'h6a, 8'h00);
		@(posedge mclk);
		reg_addr <= 7'h6a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		send(24'h7f_ffff, 24'h00_1000);
		take();
		repeat (2) @(posedge mclk);
		rchk(7'h6a, 8'h00);
		rchk(7'h6b, 8'h3f);
		rchk(7'h6a, 8'h3f);
		// Fill with the converter stalled until refused, then drain in order
		@(posedge mclk);
		n = 0;
		in_left <= 24'h00_0001;
		in_right <= 24'h00_0001;
		in_valid <= 1'b1;
		repeat (30)
		begin
			@(posedge mclk);
			if (in_ready === 1'b1)
				n++;
			in_left <= 24'(n + 1);
			in_right <= 24'(n + 1);
		end
		in_valid <= 1'b0;
		chk_reg(8'(n), 8'h11);
		for (int i = 1; i <= 17; i++)
		begin
			take();
			chk_smp(orr, 24'(i));
		end
		repeat (3) @(posedge mclk);
		chk_pin(out_valid, 1'b0);
		wr(7'h64, 8'h83);
		repeat (3) @(posedge mclk);
		chk_pin(conv_hard_reset, 1'b1);
		chk_pin(conv_out_agnd, 1'b1);
		wr(7'h64, 8'h03);
		repeat (3) @(posedge mclk);
		chk_pin(conv_out_agnd, 1'b0);
		send(VA, VB);
		wr(7'h64, 8'h43);
		repeat (3) @(posedge mclk);
		chk_pin(out_valid, 1'b0);
		rchk(7'h64, 8'h43);
		rchk(7'h68, 8'hff);
		wr(7'h64, 8'h03);
		conclude();
	end
endmodule
`default_nettype wire

// ==== testbench/sdc_bank_monitor.sv ====
// Port checker for the playback control bank, bound to the top module
`default_nettype none
module sdc_bank_monitor (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [sdc_pkg::SAMPLE_W-1:0] out_left,
	input wire logic [sdc_pkg::SAMPLE_W-1:0] out_right,
	input wire logic dev_irq,
	input wire logic conv_hard_reset,
	input wire logic conv_out_agnd,
	input wire logic conv_clk_en,
	input wire logic [1:0] interpolation_ratio,
	input wire logic left_zero_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic irq_sel_ff;
	logic dig_ff;
	logic full_ff;
	logic [2:0] idle_cnt_ff;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// Shadow of the interrupt select bit, updated at the same edge as the register
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_sel_ff <= 1'b0;
		else if (reg_wr && reg_addr == sdc_pkg::ADDR_PIN_FUNCTION)
			irq_sel_ff <= reg_wdata[sdc_pkg::LEFT_PIN_IRQ_SELECT_BIT];
	end
	// Shadow of either reset bit; while set the playback path is cleared on purpose
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			dig_ff <= 1'b0;
		else if (reg_wr && reg_addr == sdc_pkg::ADDR_RESET_ROUTING)
			dig_ff <= reg_wdata[7] | reg_wdata[6];
	end
	// Shadow of the full reset bit alone; the converter controls follow it one edge later
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			full_ff <= 1'b0;
		else if (reg_wr && reg_addr == sdc_pkg::ADDR_RESET_ROUTING)
			full_ff <= reg_wdata[sdc_pkg::FULL_RESET_POWERDOWN_BIT];
	end
	// Idle run of the clock enable; a margin of two covers a divider restart
	always_ff @(posedge mclk)
	begin
		if (!rst_n || dig_ff || conv_clk_en)
			idle_cnt_ff <= 3'h0;
		else if (idle_cnt_ff != 3'h7)
			idle_cnt_ff <= idle_cnt_ff + 3'h1;
	end
	sequence unmapped_read;
		reg_rd && (reg_addr < sdc_pkg::ADDR_RESET_ROUTING || reg_addr > sdc_pkg::ADDR_RIGHT_PEAK);
	endsequence
	sequence peak_read;
		reg_rd && (reg_addr == sdc_pkg::ADDR_LEFT_PEAK || reg_addr == sdc_pkg::ADDR_RIGHT_PEAK);
	endsequence
	sequence stalled_out;
		out_valid && !out_ready && !reg_wr && !dig_ff;
	endsequence
	a_ground_tracks_reset: assert property (conv_out_agnd == conv_hard_reset && conv_hard_reset == $past(full_ff))
		else $error("analog ground output differs from hard reset");
	a_ratio_never_reserved: assert property (interpolation_ratio != sdc_pkg::RATIO_RESERVED)
		else $error("reserved interpolation code reached the converter");
	a_unmapped_reads_zero: assert property (unmapped_read |=> reg_rdata == 8'h00)
		else $error("unmapped read returned nonzero data");
	a_peak_upper_zero: assert property (peak_read |=> reg_rdata[7:6] == 2'b00)
		else $error("peak register upper bits not zero");
	a_divider_pulses: assert property (idle_cnt_ff < 3'h5)
		else $error("converter clock enable missing too long");
	a_irq_pin_pass: assert property (irq_sel_ff |=> left_zero_pin == $past(dev_irq))
		else $error("left pin does not carry the interrupt");
	a_rdata_held: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	a_out_stall_hold: assert property (stalled_out |=> out_valid && $stable(out_left) && $stable(out_right))
		else $error("output pair changed while stalled");
	a_ready_after_reset: assert property ($rose(rst_n) |-> ##[1:2] in_ready)
		else $error("input not ready after reset");
endmodule
bind sdc_bank sdc_bank_monitor mon (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .in_ready,
	.out_valid, .out_ready, .out_left, .out_right, .dev_irq, .conv_hard_reset, .conv_out_agnd, .conv_clk_en,
	.interpolation_ratio, .left_zero_pin);
`default_nettype wire
